// [shared/gpw_pkg.sv]
// constants shared by the pin, pwm and wake control block
//==============================================================================
package gpw_pkg;
    //==========================================================================
    // register addresses
    localparam logic [7:0] GPW_ADDR_DRIVE_SHARED = 8'h46;
    localparam logic [7:0] GPW_ADDR_DRIVE_DED    = 8'h47;
    localparam logic [7:0] GPW_ADDR_DIRECTION    = 8'h49;
    localparam logic [7:0] GPW_ADDR_PWM_SHARED   = 8'h4A;
    localparam logic [7:0] GPW_ADDR_PWM_DED      = 8'h4B;
    localparam logic [7:0] GPW_ADDR_DUTY         = 8'h4C;
    localparam logic [7:0] GPW_ADDR_WAKE         = 8'h4D;
    //==========================================================================
    // field layout and reset values
    localparam int         GPW_DED_LSB   = 2;
    localparam int         GPW_DED_MSB   = 4;
    localparam logic [7:0] GPW_DED_MASK  = 8'h1C;
    localparam logic [7:0] GPW_REG_RESET = 8'h00;
    //==========================================================================
    // duty thresholds
    localparam logic [7:0] GPW_DUTY_ON_MAX  = 8'h0A;
    localparam logic [7:0] GPW_DUTY_OFF_MIN = 8'hFA;
    //==========================================================================
    // timing
    localparam int          GPW_CLK_HZ       = 10_000_000;
    localparam int          GPW_SAMPLE_MS    = 16;
    localparam int          GPW_SAMPLE_CYC   = GPW_CLK_HZ / 1000 * GPW_SAMPLE_MS;
    localparam logic [23:0] GPW_SAMPLE_LAST  = 24'(GPW_SAMPLE_CYC - 1);
endpackage

// [rtl/gpw_sync2.sv]
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module gpw_sync2 #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // data
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            meta_r <= '0;
            q_r    <= '0;
        end else begin
            meta_r <= i_d;
            q_r    <= meta_r;
        end
    end
    assign o_q = q_r;
endmodule
`default_nettype wire

// [rtl/gpw_pwm_cmp.sv]
// duty comparator with always-on and always-off bands
`timescale 1ns/1ps
`default_nettype none
module gpw_pwm_cmp
    import gpw_pkg::*;
(
    // counter and duty
    input  wire logic [7:0] i_cnt,
    input  wire logic [7:0] i_duty,
    // waveform
    output logic            o_wave
);
    always_comb begin
        if (i_duty <= GPW_DUTY_ON_MAX) begin
            o_wave = 1'b1;
        end else if (i_duty >= GPW_DUTY_OFF_MIN) begin
            o_wave = 1'b0;
        end else begin
            // higher code means less on time
            o_wave = i_cnt >= i_duty;
        end
    end
endmodule
`default_nettype wire

// [rtl/gpw_ctrl.sv]
// dedicated pin and shared drive line control with pwm and sleep wake
`timescale 1ns/1ps
`default_nettype none
module gpw_ctrl
    import gpw_pkg::*;
#(
    parameter int SAMPLE_CYC = GPW_SAMPLE_CYC
) (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // setup register port from the serial slave
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    output logic      [7:0] o_reg_rdata,
    output logic            o_reg_ack,
    // device state
    input  wire logic       i_measuring,
    input  wire logic       i_sleep,
    input  wire logic [7:0] i_burst,
    // dedicated pins
    input  wire logic [2:0] i_ded_pin,
    output logic      [2:0] o_ded_pin,
    output logic      [2:0] o_ded_pin_oe_n,
    // shared drive lines
    output logic      [7:0] o_shared_drive_lines,
    // sampled pin state and change line
    output logic      [2:0] o_ded_state,
    output logic            o_change
);
    //==========================================================================
    // registers
    logic [7:0] drv_sh_r, drv_sh_nxt;
    logic [7:0] drv_dd_r, drv_dd_nxt;
    logic [7:0] dir_r, dir_nxt;
    logic [7:0] pwm_sh_r, pwm_sh_nxt;
    logic [7:0] pwm_dd_r, pwm_dd_nxt;
    logic [7:0] duty_r, duty_nxt;
    logic [7:0] wake_r, wake_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic       ack_r, ack_nxt;

    always_comb begin
        drv_sh_nxt = drv_sh_r;
        drv_dd_nxt = drv_dd_r;
        dir_nxt    = dir_r;
        pwm_sh_nxt = pwm_sh_r;
        pwm_dd_nxt = pwm_dd_r;
        duty_nxt   = duty_r;
        wake_nxt   = wake_r;
        rdata_nxt  = rdata_r;
        ack_nxt    = i_reg_wr | i_reg_rd;
        // one register per strobe; the slave steps the address for blocks
        if (i_reg_wr) begin
            case (i_reg_addr)
                GPW_ADDR_DRIVE_SHARED: drv_sh_nxt = i_reg_wdata;
                GPW_ADDR_DRIVE_DED:    drv_dd_nxt = i_reg_wdata & GPW_DED_MASK;
                GPW_ADDR_DIRECTION:    dir_nxt    = i_reg_wdata & GPW_DED_MASK;
                GPW_ADDR_PWM_SHARED:   pwm_sh_nxt = i_reg_wdata;
                GPW_ADDR_PWM_DED:      pwm_dd_nxt = i_reg_wdata & GPW_DED_MASK;
                GPW_ADDR_DUTY:         duty_nxt   = i_reg_wdata;
                GPW_ADDR_WAKE:         wake_nxt   = i_reg_wdata & GPW_DED_MASK;
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                GPW_ADDR_DRIVE_SHARED: rdata_nxt = drv_sh_r;
                GPW_ADDR_DRIVE_DED:    rdata_nxt = drv_dd_r;
                GPW_ADDR_DIRECTION:    rdata_nxt = dir_r;
                GPW_ADDR_PWM_SHARED:   rdata_nxt = pwm_sh_r;
                GPW_ADDR_PWM_DED:      rdata_nxt = pwm_dd_r;
                GPW_ADDR_DUTY:         rdata_nxt = duty_r;
                GPW_ADDR_WAKE:         rdata_nxt = wake_r;
                default:               rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            drv_sh_r <= GPW_REG_RESET;
            drv_dd_r <= GPW_REG_RESET;
            dir_r    <= GPW_REG_RESET;
            pwm_sh_r <= GPW_REG_RESET;
            pwm_dd_r <= GPW_REG_RESET;
            duty_r   <= GPW_REG_RESET;
            wake_r   <= GPW_REG_RESET;
            rdata_r  <= 8'h00;
            ack_r    <= 1'b0;
        end else begin
            drv_sh_r <= drv_sh_nxt;
            drv_dd_r <= drv_dd_nxt;
            dir_r    <= dir_nxt;
            pwm_sh_r <= pwm_sh_nxt;
            pwm_dd_r <= pwm_dd_nxt;
            duty_r   <= duty_nxt;
            wake_r   <= wake_nxt;
            rdata_r  <= rdata_nxt;
            ack_r    <= ack_nxt;
        end
    end
    assign o_reg_rdata = rdata_r;
    assign o_reg_ack   = ack_r;

    //==========================================================================
    // pwm counter and waveform
    logic [7:0] pcnt_r, pcnt_nxt;
    logic       wave_r, wave_nxt;
    logic       wave_c;

    gpw_pwm_cmp u_cmp (
        .i_cnt  (pcnt_r),
        .i_duty (duty_r),
        .o_wave (wave_c)
    );

    always_comb begin
        // frozen while bursts run, so duty accuracy depends on burst length
        pcnt_nxt = i_measuring ? pcnt_r : pcnt_r + 8'h01;
        wave_nxt = i_measuring ? wave_r : wave_c;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pcnt_r <= 8'h00;
            wave_r <= 1'b0;
        end else begin
            pcnt_r <= pcnt_nxt;
            wave_r <= wave_nxt;
        end
    end

    //==========================================================================
    // pin drive
    logic [2:0] ded_dir;
    logic [2:0] ded_pwm;
    logic [2:0] ded_drv;
    logic [7:0] sh_val;
    logic [2:0] ded_out_r, ded_out_nxt;
    logic [2:0] ded_oen_r, ded_oen_nxt;
    logic [7:0] sh_out_r, sh_out_nxt;

    assign ded_dir = dir_r[GPW_DED_MSB:GPW_DED_LSB];
    assign ded_pwm = pwm_dd_r[GPW_DED_MSB:GPW_DED_LSB] & ded_dir;
    assign ded_drv = drv_dd_r[GPW_DED_MSB:GPW_DED_LSB];

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            sh_val[i] = pwm_sh_r[i] ? wave_r : drv_sh_r[i];
        end
        for (int i = 0; i < 3; i++) begin
            ded_out_nxt[i] = ded_pwm[i] ? wave_r : ded_drv[i];
        end
        ded_oen_nxt = ~ded_dir;
        // shared lines never float; bursts replace values in measurement
        sh_out_nxt  = i_measuring ? i_burst : sh_val;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ded_out_r <= 3'h0;
            ded_oen_r <= 3'h7;
            sh_out_r  <= 8'h00;
        end else begin
            ded_out_r <= ded_out_nxt;
            ded_oen_r <= ded_oen_nxt;
            sh_out_r  <= sh_out_nxt;
        end
    end
    assign o_ded_pin            = ded_out_r;
    assign o_ded_pin_oe_n       = ded_oen_r;
    assign o_shared_drive_lines = sh_out_r;

    //==========================================================================
    // input sampling and wake
    logic [2:0]  pin_sync;
    logic [23:0] tick_r, tick_nxt;
    logic [2:0]  state_r, state_nxt;
    logic        chg_r, chg_nxt;
    logic        tick_hit;
    logic [2:0]  watch;

    gpw_sync2 #(.W(3)) u_sync (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_d   (i_ded_pin),
        .o_q   (pin_sync)
    );

    assign tick_hit = tick_r == 24'(SAMPLE_CYC - 1);
    assign watch    = ~ded_dir & wake_r[GPW_DED_MSB:GPW_DED_LSB];

    always_comb begin
        tick_nxt  = tick_hit ? 24'h000000 : tick_r + 24'h000001;
        state_nxt = state_r;
        chg_nxt   = 1'b0;
        if (tick_hit) begin
            for (int i = 0; i < 3; i++) begin
                // in sleep only wake-enabled inputs are read
                if (!ded_dir[i] && (!i_sleep || watch[i])) begin
                    state_nxt[i] = pin_sync[i];
                end
            end
            chg_nxt = i_sleep && |((pin_sync ^ state_r) & watch);
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            tick_r  <= 24'h000000;
            state_r <= 3'h0;
            chg_r   <= 1'b0;
        end else begin
            tick_r  <= tick_nxt;
            state_r <= state_nxt;
            chg_r   <= chg_nxt;
        end
    end
    assign o_ded_state = state_r;
    assign o_change    = chg_r;

    //==========================================================================
    // checks
    property p_dir_oe;
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |=> (o_ded_pin_oe_n == ~$past(ded_dir));
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("oe does not follow direction");

    property p_dir_bits;
        @(posedge i_clk) disable iff (i_rst)
        (dir_r & ~GPW_DED_MASK) == 8'h00;
    endproperty
    a_dir_bits: assert property (p_dir_bits) else $error("direction reserved bits set");

    property p_sample_only_tick;
        @(posedge i_clk) disable iff (i_rst)
        !tick_hit |=> $stable(state_r);
    endproperty
    a_sample_only_tick: assert property (p_sample_only_tick) else $error("sample off tick");

    property p_burst;
        @(posedge i_clk) disable iff (i_rst)
        i_measuring |=> (o_shared_drive_lines == $past(i_burst));
    endproperty
    a_burst: assert property (p_burst) else $error("shared lines not bursting");

    property p_freeze;
        @(posedge i_clk) disable iff (i_rst)
        i_measuring |=> $stable(wave_r) && $stable(pcnt_r);
    endproperty
    a_freeze: assert property (p_freeze) else $error("pwm moved in measurement");

    property p_on_band;
        @(posedge i_clk) disable iff (i_rst)
        (duty_r <= GPW_DUTY_ON_MAX) && !i_measuring |=> wave_r;
    endproperty
    a_on_band: assert property (p_on_band) else $error("low code not always on");

    property p_off_band;
        @(posedge i_clk) disable iff (i_rst)
        (duty_r >= GPW_DUTY_OFF_MIN) && !i_measuring |=> !wave_r;
    endproperty
    a_off_band: assert property (p_off_band) else $error("high code not always off");

    property p_input_no_pwm;
        @(posedge i_clk) disable iff (i_rst)
        !ded_dir[0] && !i_reg_wr |=> (o_ded_pin[0] == $past(ded_drv[0]));
    endproperty
    a_input_no_pwm: assert property (p_input_no_pwm) else $error("pwm on input pin");

    property p_change;
        @(posedge i_clk) disable iff (i_rst)
        o_change |-> $past(i_sleep) && $past(tick_hit);
    endproperty
    a_change: assert property (p_change) else $error("change outside sleep tick");
endmodule
`default_nettype wire

// [testbench/gpw_host_model.sv]
// host side model issuing setup register accesses
`timescale 1ns/1ps
`default_nettype none
module gpw_host_model (
    // clock
    input  wire logic       i_clk,
    // register port answer
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_ack,
    // register port request
    output logic      [7:0] o_addr,
    output logic      [7:0] o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // one byte per access; a block is a run of calls with stepping address
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w,
                          output logic [7:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= w;
        o_rd    <= ~w;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_rd <= 1'b0;
        @(negedge i_clk);
        while (i_ack !== 1'b1 && n < 4) begin
            n++;
            @(negedge i_clk);
        end
        q = i_rdata;
    endtask
endmodule
`default_nettype wire

// [testbench/gpw_ctrl_bench.sv]
// self-checking bench for the pin, pwm and wake control block
`timescale 1ns/1ps
`default_nettype none
module gpw_ctrl_bench;
    import gpw_pkg::*;
    localparam int SC = 20;
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       i_measuring = 1'b0;
    logic       i_sleep = 1'b0;
    logic [7:0] i_burst = 8'h00;
    logic [2:0] ext_pin = 3'h0;
    logic [7:0] addr, wdata, rdata, shared;
    logic       wr, rd, ack, change;
    logic [2:0] pin_in, pin_out, oe_n, ded_state;
    int         err_count = 0;
    int         checks_done = 0;
    always #50 i_clk = ~i_clk;
    // pin level: the block wins where it drives, else the outside source
    assign pin_in = (oe_n & ext_pin) | (~oe_n & pin_out);
    gpw_host_model i_gpw_host_model (.i_clk(i_clk), .i_rdata(rdata), .i_ack(ack),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    gpw_ctrl #(.SAMPLE_CYC(SC)) i_gpw_ctrl (.i_clk(i_clk), .i_rst(i_rst),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .o_reg_ack(ack), .i_measuring(i_measuring),
        .i_sleep(i_sleep), .i_burst(i_burst), .i_ded_pin(pin_in), .o_ded_pin(pin_out),
        .o_ded_pin_oe_n(oe_n), .o_shared_drive_lines(shared), .o_ded_state(ded_state),
        .o_change(change));
    //==========================================================================
    // helpers
    task automatic test_done;
        if (err_count == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        i_gpw_host_model.access(a, d, 1'b1, q);
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] q;
        i_gpw_host_model.access(a, 8'h00, 1'b0, q);
        chk("register", {8'h00, e}, {8'h00, q});
    endtask
    // counts cycles with shared line 0 high, or change pulses, over a span
    task automatic count(input int cyc, input logic sel, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge i_clk);
            if ((sel ? change : shared[0]) === 1'b1) begin
                n++;
            end
        end
    endtask
    //==========================================================================
    // tests
    initial begin
        int n;
        logic [2:0] held;
        logic [7:0] duty [7] = '{8'h00, 8'h0A, 8'h0B, 8'h80, 8'hF9, 8'hFA, 8'hFF};
        int hi [7] = '{256, 256, 245, 128, 7, 0, 0};
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int a = 8'h49; a <= 8'h4D; a++) begin
            rreg(8'(a), GPW_REG_RESET);
        end
        chk("oe_n", 16'h7, {13'h0, oe_n});
        rreg(8'h50, 8'h00);
        wreg(GPW_ADDR_DIRECTION, 8'hFF);
        rreg(GPW_ADDR_DIRECTION, 8'h1C);
        chk("oe_n", 16'h0, {13'h0, oe_n});
        wreg(GPW_ADDR_PWM_DED, 8'hFF);
        rreg(GPW_ADDR_PWM_DED, 8'h1C);
        wreg(GPW_ADDR_PWM_SHARED, 8'hFF);
        rreg(GPW_ADDR_PWM_SHARED, 8'hFF);
        wreg(GPW_ADDR_WAKE, 8'hFF);
        rreg(GPW_ADDR_WAKE, 8'h1C);
        wreg(GPW_ADDR_PWM_DED, 8'h00);
        wreg(GPW_ADDR_PWM_SHARED, 8'h00);
        wreg(GPW_ADDR_DRIVE_DED, 8'h14);
        wreg(GPW_ADDR_DRIVE_SHARED, 8'hA5);
        repeat (3) @(negedge i_clk);
        chk("pin", 16'h5, {13'h0, pin_out});
        chk("shared", 16'hA5, {8'h0, shared});
        @(posedge i_clk);
        i_measuring <= 1'b1;
        i_burst     <= 8'h3C;
        repeat (3) @(negedge i_clk);
        chk("shared", 16'h3C, {8'h0, shared});
        @(posedge i_clk);
        i_measuring <= 1'b0;
        repeat (3) @(negedge i_clk);
        chk("shared", 16'hA5, {8'h0, shared});
        wreg(GPW_ADDR_PWM_SHARED, 8'h01);
        for (int k = 0; k < 7; k++) begin
            wreg(GPW_ADDR_DUTY, duty[k]);
            repeat (4) @(negedge i_clk);
            count(256, 1'b0, n);
            chk("high cycles", 16'(hi[k]), 16'(n));
        end
        // a running counter would cross the 0x80 threshold within 300 cycles
        wreg(GPW_ADDR_DUTY, 8'h80);
        wreg(GPW_ADDR_PWM_DED, 8'h1C);
        @(posedge i_clk);
        i_measuring <= 1'b1;
        repeat (3) @(negedge i_clk);
        held = pin_out;
        n = 0;
        repeat (300) begin
            @(negedge i_clk);
            if (pin_out !== held) begin
                n++;
            end
        end
        chk("pwm switches", 16'h0, 16'(n));
        @(posedge i_clk);
        i_measuring <= 1'b0;
        wreg(GPW_ADDR_DUTY, 8'hFA);
        repeat (3) @(negedge i_clk);
        chk("pin", 16'h0, {13'h0, pin_out});
        wreg(GPW_ADDR_DIRECTION, 8'h18);
        repeat (3) @(negedge i_clk);
        chk("oe_n", 16'h1, {13'h0, oe_n});
        chk("pin", 16'h1, {13'h0, pin_out});
        wreg(GPW_ADDR_PWM_DED, 8'h00);
        wreg(GPW_ADDR_DIRECTION, 8'h00);
        wreg(GPW_ADDR_WAKE, 8'h04);
        count(2 * SC + 6, 1'b1, n);
        @(posedge i_clk);
        i_sleep <= 1'b1;
        ext_pin <= 3'b001;
        count(2 * SC + 6, 1'b1, n);
        chk("change pulses", 16'h1, 16'(n));
        chk("state", 16'h1, {13'h0, ded_state});
        @(posedge i_clk);
        ext_pin <= 3'b011;
        count(3 * SC, 1'b1, n);
        chk("change pulses", 16'h0, 16'(n));
        @(posedge i_clk);
        i_sleep <= 1'b0;
        count(2 * SC + 6, 1'b1, n);
        chk("change pulses", 16'h0, 16'(n));
        chk("state", 16'h3, {13'h0, ded_state});
        test_done;
    end
    //==========================================================================
    // watchdog
    initial begin
        repeat (20000) @(posedge i_clk);
        err_count++;
        test_done;
    end
endmodule
`default_nettype wire
